/* File: hdl/scb_pkg.sv */
// Shared constants, types and helpers of the SDRAM command and burst logic.
// Assumes a single clock domain; pins are sampled on the rising edge.
package scb_pkg;

    // Array geometry
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int DQ_W = 32;
    localparam int MASK_W = 4;
    localparam int BYTE_W = 8;
    localparam int MEM_AW = BANK_W + ROW_W + COL_W;

    // Mode word fields
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BL_W = 3;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_CL_W = 3;
    localparam int AP_BIT = 10;
    localparam logic [ROW_W-1:0] MODE_RESET = 11'h032;

    // Burst length and latency codes
    localparam logic [MODE_BL_W-1:0] BL_1 = 3'h0;
    localparam logic [MODE_BL_W-1:0] BL_2 = 3'h1;
    localparam logic [MODE_BL_W-1:0] BL_4 = 3'h2;
    localparam logic [MODE_BL_W-1:0] BL_8 = 3'h3;
    localparam logic [MODE_BL_W-1:0] BL_FULL = 3'h7;
    localparam logic [MODE_CL_W-1:0] CL_2 = 3'h2;

    // Column counter steps and buffer size
    localparam logic [COL_W-1:0] COL_ZERO = 8'h00;
    localparam logic [COL_W-1:0] COL_ONE = 8'h01;
    localparam logic [1:0] BUF_ENTRIES = 2'h2;

    // Decoded commands
    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST
    } scb_cmd_e;

    // Burst engine states
    typedef enum logic [1:0] {
        BURST_IDLE, BURST_RD, BURST_WR
    } scb_burst_e;

    // Command, address and mask pins
    typedef struct packed {
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic cke;
        logic [MASK_W-1:0] dqm;
        logic [ROW_W-1:0] addr;
        logic bankSelectHigh;
        logic bankSelectLow;
    } scb_pins_s;

    // One buffered write word
    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [DQ_W-1:0] data;
        logic [MASK_W-1:0] be;
    } scb_wr_s;

    // Strobe pattern to command
    function automatic scb_cmd_e decodeCmd(input scb_pins_s p);
        scb_cmd_e c;
        c = CMD_DESEL;
        if (!p.csN && p.cke) begin
            case ({p.rasN, p.casN, p.weN})
                3'h7: c = CMD_NOP;
                3'h3: c = CMD_ACT;
                3'h2: c = CMD_PRE;
                3'h5: c = CMD_RD;
                3'h4: c = CMD_WR;
                3'h1: c = CMD_REF;
                3'h0: c = CMD_MRS;
                3'h6: c = CMD_BST;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    // Wrap mask of the burst-length code
    function automatic logic [COL_W-1:0] lenMask(input logic [MODE_BL_W-1:0] code);
        logic [COL_W-1:0] m;
        case (code)
            BL_2: m = 8'h01;
            BL_4: m = 8'h03;
            BL_8: m = 8'h07;
            BL_FULL: m = 8'hFF;
            default: m = COL_ZERO;
        endcase
        return m;
    endfunction

    // Column of beat idx, wrapped inside the burst boundary
    function automatic logic [COL_W-1:0] burstCol(input logic [COL_W-1:0] start,
            input logic [COL_W-1:0] idx, input logic [COL_W-1:0] mask, input logic il);
        logic [COL_W-1:0] w;
        w = il ? (start ^ idx) : (start + idx);
        return (start & ~mask) | (w & mask);
    endfunction

endpackage

/* File: hdl/scb_mem.sv */
// Cell array of all banks: byte-masked write port, registered read port.
// Assumes one clock; a read and write of one word on one edge forwards the new bytes.
`timescale 1ns/10ps
module scb_mem #(
    parameter int AW = scb_pkg::MEM_AW,
    parameter int DW = scb_pkg::DQ_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic [DW/scb_pkg::BYTE_W-1:0] wrBe,
    // Read port
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData
);
    localparam int BW = DW / scb_pkg::BYTE_W;
    localparam int BY = scb_pkg::BYTE_W;

    logic [DW-1:0] store [0:(2**AW)-1];
    logic [DW-1:0] rdData_d;
    logic [DW-1:0] rdData_q;

    // Byte-masked array write
    always_ff @(posedge clk) begin
        for (int b = 0; b < BW; b++) begin
            if (wrEn && wrBe[b]) begin
                store[wrAddr][b*BY +: BY] <= wrData[b*BY +: BY];
            end
        end
    end

    // Read word, new bytes forwarded on a same-address write
    always_comb begin
        rdData_d = rdData_q;
        if (rdEn) begin
            rdData_d = store[rdAddr];
            for (int b = 0; b < BW; b++) begin
                if (wrEn && wrBe[b] && (wrAddr == rdAddr)) begin
                    rdData_d[b*BY +: BY] = wrData[b*BY +: BY];
                end
            end
        end
    end

    // Read data register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign rdData = rdData_q;

endmodule

/* File: hdl/scb_core.sv */
// Command decoder, bank tracker and burst engine of a four-bank 32-bit SDRAM.
// Assumes the memory controller drives all pins from sys_clk and keeps its own timing.
// Functional notes
// - All strobes low is mode set; address pins load the mode word.
// - RAS high, CAS low is column access; WE picks write or read.
// - Reads and writes are accepted on every cycle, any active bank.
// - Burst type and length come from the programmed mode word.
// - Write data starts with the command, one word per edge, extras ignored.
// - A new read restarts the burst; old data flows until new latency.
// - A new write drops the old burst and runs its full length.
// - A read ends a write burst at once; leftover write data dropped.
// - Burst stop ends only full-page bursts; bank and row stay open.
// - After burst stop, reads float after latency; write data ignored.
// - Sequential bursts wrap in the low column bits, no carry above.
// - Interleaved bursts invert low column bits by beat index.
// - Read mask floats the byte two cycles on; write mask blocks at once.
// - Chip select high ignores commands; running bursts carry on.
// - Eleven row bits, eight column bits, two bank select lines.
`timescale 1ns/10ps
module scb_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Command, address and mask pins
    input wire scb_pkg::scb_pins_s cmdPins,
    // Data pins
    input wire logic [scb_pkg::DQ_W-1:0] dqIn,
    output logic [scb_pkg::DQ_W-1:0] dqOut,
    output logic [scb_pkg::MASK_W-1:0] dqOe,
    // Status
    output logic burstActive,
    output logic burstWrite,
    output logic [scb_pkg::NUM_BANKS-1:0] bankOpen,
    output logic [scb_pkg::ROW_W-1:0] modeValue
);
    localparam int AW = scb_pkg::MEM_AW;

    scb_pkg::scb_cmd_e cmd;
    logic [scb_pkg::BANK_W-1:0] cmdBank;
    logic [scb_pkg::COL_W-1:0] cmdCol;
    logic [scb_pkg::ROW_W-1:0] mode_q, mode_d;
    logic [scb_pkg::COL_W-1:0] blMask;
    logic fullPage, interleave, casLat2;
    logic [scb_pkg::ROW_W-1:0] openRow_q [scb_pkg::NUM_BANKS];
    logic [scb_pkg::ROW_W-1:0] openRow_d [scb_pkg::NUM_BANKS];
    logic [scb_pkg::NUM_BANKS-1:0] bankOpen_q, bankOpen_d;
    scb_pkg::scb_burst_e state_q, state_d;
    logic [scb_pkg::COL_W-1:0] beat_q, beat_d, start_q, start_d, curCol;
    logic [scb_pkg::BANK_W-1:0] bank_q, bank_d;
    logic rdAccess, wrAccess, bstFull, beatLive, lastBeat, stepOk, rdFetch;
    logic [AW-1:0] accAddr;
    scb_pkg::scb_wr_s bufIn, drainWord;
    scb_pkg::scb_wr_s buf_q [2];
    scb_pkg::scb_wr_s buf_d [2];
    logic [1:0] count_q, count_d;
    logic head_q, head_d;
    logic bufInValid, bufInReady, drainValid, drainReady, push, pop;
    logic [scb_pkg::DQ_W-1:0] memData, s1Data_q, s1Data_d, outData_q, outData_d;
    logic memValid_q, memValid_d, s1Valid_q, s1Valid_d, outValid_q, outValid_d;
    logic [scb_pkg::MASK_W-1:0] dqmDly_q, dqmDly_d, oe_q, oe_d;

    // Pin decode; deselect or clock enable low yields no command
    assign cmd = scb_pkg::decodeCmd(cmdPins);
    assign cmdBank = {cmdPins.bankSelectHigh, cmdPins.bankSelectLow};
    assign cmdCol = cmdPins.addr[scb_pkg::COL_W-1:0];

    // Burst shape from the mode word
    assign blMask = scb_pkg::lenMask(mode_q[scb_pkg::MODE_BL_LSB +: scb_pkg::MODE_BL_W]);
    assign fullPage = mode_q[scb_pkg::MODE_BL_LSB +: scb_pkg::MODE_BL_W] == scb_pkg::BL_FULL;
    assign interleave = mode_q[scb_pkg::MODE_BT_BIT];
    assign casLat2 = mode_q[scb_pkg::MODE_CL_LSB +: scb_pkg::MODE_CL_W] == scb_pkg::CL_2;

    // Mode word and open-row tracking
    always_comb begin
        mode_d = mode_q;
        bankOpen_d = bankOpen_q;
        openRow_d = openRow_q;
        case (cmd)
            scb_pkg::CMD_MRS: mode_d = cmdPins.addr;
            scb_pkg::CMD_ACT: begin
                bankOpen_d[cmdBank] = 1'b1;
                openRow_d[cmdBank] = cmdPins.addr;
            end
            scb_pkg::CMD_PRE: begin
                if (cmdPins.addr[scb_pkg::AP_BIT]) begin
                    bankOpen_d = '0;
                end else begin
                    bankOpen_d[cmdBank] = 1'b0;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= scb_pkg::MODE_RESET;
            bankOpen_q <= '0;
            for (int i = 0; i < scb_pkg::NUM_BANKS; i++) begin
                openRow_q[i] <= '0;
            end
        end else begin
            mode_q <= mode_d;
            bankOpen_q <= bankOpen_d;
            openRow_q <= openRow_d;
        end
    end

    // Access qualification; any cycle may carry a new access
    assign rdAccess = (cmd == scb_pkg::CMD_RD) && bankOpen_q[cmdBank];
    assign wrAccess = (cmd == scb_pkg::CMD_WR) && bankOpen_q[cmdBank];
    assign bstFull = (cmd == scb_pkg::CMD_BST) && fullPage;
    assign beatLive = (state_q != scb_pkg::BURST_IDLE) && !rdAccess && !wrAccess && !bstFull;
    assign curCol = scb_pkg::burstCol(start_q, beat_q, blMask, interleave);
    assign lastBeat = !fullPage && (beat_q == blMask);
    assign stepOk = beatLive && ((state_q == scb_pkg::BURST_RD) || bufInReady);

    // Word address of this cycle's beat, row latched at activate
    assign accAddr = (rdAccess || wrAccess) ? {cmdBank, openRow_q[cmdBank], cmdCol}
                                            : {bank_q, openRow_q[bank_q], curCol};

    // Burst engine next state
    always_comb begin
        state_d = state_q;
        beat_d = beat_q;
        start_d = start_q;
        bank_d = bank_q;
        if (stepOk) begin
            if (lastBeat) begin
                state_d = scb_pkg::BURST_IDLE;
            end else begin
                beat_d = beat_q + scb_pkg::COL_ONE;
            end
        end
        if (rdAccess || wrAccess) begin
            // New access overrides what is left of the old burst
            state_d = rdAccess ? scb_pkg::BURST_RD : scb_pkg::BURST_WR;
            start_d = cmdCol;
            bank_d = cmdBank;
            beat_d = scb_pkg::COL_ONE;
            if ((blMask == scb_pkg::COL_ZERO) && !fullPage) begin
                state_d = scb_pkg::BURST_IDLE;
            end
        end else if (bstFull) begin
            state_d = scb_pkg::BURST_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= scb_pkg::BURST_IDLE;
            beat_q <= scb_pkg::COL_ZERO;
            start_q <= scb_pkg::COL_ZERO;
            bank_q <= '0;
        end else begin
            state_q <= state_d;
            beat_q <= beat_d;
            start_q <= start_d;
            bank_q <= bank_d;
        end
    end

    // Write words from the pins; none after the burst or on an interrupt
    assign bufInValid = wrAccess || ((state_q == scb_pkg::BURST_WR) && beatLive);
    assign bufIn.addr = accAddr;
    assign bufIn.data = dqIn;
    assign bufIn.be = ~cmdPins.dqm;
    assign rdFetch = rdAccess || ((state_q == scb_pkg::BURST_RD) && beatLive);

    // Two-entry write buffer; retirement waits while clock enable is low
    assign bufInReady = count_q != scb_pkg::BUF_ENTRIES;
    assign drainValid = count_q != 2'h0;
    assign drainReady = cmdPins.cke;
    assign push = bufInValid && bufInReady;
    assign pop = drainValid && drainReady;
    assign drainWord = buf_q[head_q];

    always_comb begin
        buf_d = buf_q;
        head_d = head_q;
        count_d = count_q;
        if (push) begin
            buf_d[head_q ^ count_q[0]] = bufIn;
        end
        if (pop) begin
            head_d = ~head_q;
        end
        case ({push, pop})
            2'h2: count_d = count_q + 2'h1;
            2'h1: count_d = count_q - 2'h1;
            default: count_d = count_q;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            head_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            buf_q <= buf_d;
            head_q <= head_d;
            count_q <= count_d;
        end
    end

    // Cell array
    scb_mem #(
        .AW(AW),
        .DW(scb_pkg::DQ_W)
    ) u_mem (
        .clk(sys_clk),
        .rstn(rstn),
        .wrEn(pop),
        .wrAddr(drainWord.addr),
        .wrData(drainWord.data),
        .wrBe(drainWord.be),
        .rdEn(rdFetch),
        .rdAddr(accAddr),
        .rdData(memData)
    );

    // Read pipeline to the CAS latency; a write takes the bus over
    always_comb begin
        memValid_d = rdFetch;
        s1Valid_d = memValid_q && !wrAccess;
        s1Data_d = memData;
        outValid_d = (casLat2 ? memValid_q : s1Valid_q) && !wrAccess;
        outData_d = casLat2 ? memData : s1Data_q;
        dqmDly_d = cmdPins.dqm;
        oe_d = {scb_pkg::MASK_W{outValid_d}} & ~dqmDly_q;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            memValid_q <= 1'b0;
            s1Valid_q <= 1'b0;
            outValid_q <= 1'b0;
            s1Data_q <= '0;
            outData_q <= '0;
            dqmDly_q <= '0;
            oe_q <= '0;
        end else begin
            memValid_q <= memValid_d;
            s1Valid_q <= s1Valid_d;
            outValid_q <= outValid_d;
            s1Data_q <= s1Data_d;
            outData_q <= outData_d;
            dqmDly_q <= dqmDly_d;
            oe_q <= oe_d;
        end
    end

    // Status and data outputs
    assign dqOut = outData_q;
    assign dqOe = oe_q;
    assign burstActive = state_q != scb_pkg::BURST_IDLE;
    assign burstWrite = state_q == scb_pkg::BURST_WR;
    assign bankOpen = bankOpen_q;
    assign modeValue = mode_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_mode_load: assert property (cmd == scb_pkg::CMD_MRS |=> modeValue == $past(cmdPins.addr))
        else $error("mode word not loaded");
    chk_read_start: assert property (rdAccess && (blMask != scb_pkg::COL_ZERO) |=>
        state_q == scb_pkg::BURST_RD && beat_q == scb_pkg::COL_ONE && start_q == $past(cmdCol))
        else $error("read did not restart burst");
    chk_back_to_back: assert property (burstActive && (rdAccess || wrAccess) |=>
        start_q == $past(cmdCol) && bank_q == $past(cmdBank))
        else $error("access during burst not taken");
    chk_rd_latency: assert property (rdAccess && !casLat2 ##1 !wrAccess ##1 !wrAccess |->
        ##1 outValid_q)
        else $error("read data late");
    chk_dqm_float: assert property (cmdPins.dqm[0] |-> ##2 !dqOe[0])
        else $error("masked byte driven");
    chk_wr_capture: assert property (wrAccess && count_q == 2'h0 |=> drainValid &&
        drainWord.data == $past(dqIn) && drainWord.be == ~$past(cmdPins.dqm))
        else $error("write word not captured");
    chk_rd_ends_wr: assert property (burstWrite && rdAccess |-> !bufInValid ##1 !burstWrite)
        else $error("write not ended by read");
    chk_bstop_end: assert property (bstFull && !rdAccess |=> !burstActive)
        else $error("burst stop ignored");
    chk_bstop_float: assert property (bstFull ##1 !rdAccess ##1 !rdAccess |-> ##1 !outValid_q)
        else $error("data after burst stop");
    chk_cs_hold: assert property (cmdPins.csN |=> $stable(modeValue) &&
        $stable(bankOpen) && $stable(start_q) && $stable(bank_q) &&
        (!$past(burstActive) || $past(lastBeat) || burstActive))
        else $error("deselect changed state");
    chk_seq_wrap: assert property (stepOk && !lastBeat && !interleave && !fullPage |=>
        ((curCol & ~blMask) == ($past(curCol) & ~blMask)) &&
        (((curCol - $past(curCol)) & blMask) == (scb_pkg::COL_ONE & blMask)))
        else $error("carry out of burst boundary");
    chk_il_pattern: assert property (burstActive && interleave && !fullPage |->
        (curCol ^ start_q) == (beat_q & blMask))
        else $error("interleave order wrong");
    chk_full_step: assert property (fullPage && state_q == scb_pkg::BURST_RD &&
        cmd == scb_pkg::CMD_NOP |=> burstActive && beat_q == $past(beat_q) + scb_pkg::COL_ONE)
        else $error("full page did not step");

endmodule

/* File: bench/scb_ctrl_model.sv */
// Memory controller model: power-up pause, precharge, mode set, refreshes,
// then drives the pins for the bench. Assumes sys_clk and active-low rstn.
`timescale 1ns/10ps
module scb_ctrl_model #(
    parameter int PAUSE_CYC = 20000,
    parameter int RSC_CYC = 2,
    parameter logic [10:0] MODE = 11'h022
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Pins towards the device
    output scb_pkg::scb_pins_s cmdPins,
    output logic [31:0] dqIn,
    // Status
    output logic initDone
);
    // One cycle; a released data bus shows the inverse of its last value
    task automatic drv(input scb_pkg::scb_pins_s p, input logic [32:0] d);
        cmdPins = p;
        dqIn = d[32] ? d[31:0] : ~dqIn;
        @(posedge sys_clk);
        #1;
    endtask

    // Strobe pattern with clock enable high, bank zero
    function automatic scb_pkg::scb_pins_s pin(input logic [2:0] c, input logic [10:0] a,
            input logic [3:0] m);
        return '{csN: 1'b0, rasN: c[2], casN: c[1], weN: c[0], cke: 1'b1, dqm: m,
                 addr: a, bankSelectHigh: 1'b0, bankSelectLow: 1'b0};
    endfunction

    // Power-up order, then hand over
    initial begin
        initDone = 1'b0;
        cmdPins = pin(3'h7, 11'h0, 4'hF);
        dqIn = 32'h0;
        @(posedge sys_clk iff rstn);
        #1;
        repeat (PAUSE_CYC) drv(pin(3'h7, 11'h0, 4'hF), 33'h0);
        drv(pin(3'h2, 11'h400, 4'hF), 33'h0);
        drv(pin(3'h7, 11'h0, 4'h0), 33'h0);
        drv(pin(3'h0, MODE, 4'h0), 33'h0);
        repeat (RSC_CYC) drv(pin(3'h7, 11'h0, 4'h0), 33'h0);
        repeat (8) begin
            drv(pin(3'h1, 11'h0, 4'h0), 33'h0);
            drv(pin(3'h7, 11'h0, 4'h0), 33'h0);
        end
        initDone = 1'b1;
        drv(pin(3'h7, 11'h0, 4'h0), 33'h0);
    end
endmodule

/* File: bench/scb_core_tb_top.sv */
// Bench of the SDRAM command and burst logic, driving pins through the model.
// Assumes each step drives 1 ns after a rising edge and looks after the next.
`timescale 1ns/10ps
module scb_core_tb_top;
    localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4;
    localparam logic [3:0] MRS = 4'h0, BST = 4'h6, DSW = 4'hC;
    localparam logic [32:0] Z = 33'h0;
    logic sys_clk, rstn, initDone, burstActive, burstWrite;
    scb_pkg::scb_pins_s cmdPins;
    logic [31:0] dqIn, dqOut;
    logic [3:0] dqOe, bankOpen, mk;
    logic [10:0] modeValue;
    int error_cnt, compares, i;

    // Device and controller
    scb_core uut (.sys_clk(sys_clk), .rstn(rstn), .cmdPins(cmdPins), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe), .burstActive(burstActive), .burstWrite(burstWrite),
        .bankOpen(bankOpen), .modeValue(modeValue));
    scb_ctrl_model ctrl (.sys_clk(sys_clk), .rstn(rstn), .cmdPins(cmdPins), .dqIn(dqIn),
        .initDone(initDone));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Word pattern of a column, and sequential four-beat column
    function automatic logic [31:0] wd(input logic [7:0] c);
        return {~c, 8'h3C, c, 8'hA5};
    endfunction
    function automatic logic [7:0] sq(input logic [7:0] c, input int k);
        return (c & 8'hFC) | ((c + 8'(k)) & 8'h03);
    endfunction

    task automatic fail(input string m);
        error_cnt++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic cmpv(input logic [10:0] g, input logic [10:0] e);
        compares++;
        if (g !== e) fail("status value");
    endtask
    // Enables and enabled bytes against a column word; 5 means no look
    task automatic chk(input logic [3:0] eo, input logic [7:0] ec);
        logic [31:0] bm;
        bm = {{8{eo[3]}}, {8{eo[2]}}, {8{eo[1]}}, {8{eo[0]}}};
        if (eo != 4'h5) begin
            compares++;
            if (dqOe !== eo || (dqOut & bm) !== (wd(ec) & bm)) fail("read word");
        end
    endtask
    // One clock step on bank 2, then a look at the data pins
    task automatic st(input logic [3:0] c, input logic [10:0] a, input logic [32:0] d,
            input logic [3:0] eo, input logic [7:0] ec);
        scb_pkg::scb_pins_s p;
        p = '{csN: c[3], rasN: c[2], casN: c[1], weN: c[0], cke: 1'b1, dqm: mk, addr: a,
              bankSelectHigh: 1'b1, bankSelectLow: 1'b0};
        ctrl.drv(p, d);
        chk(eo, ec);
    endtask
    task automatic nops(input int n);
        repeat (n) st(NOP, 11'h0, Z, 4'h0, 8'h0);
    endtask
    // Four-beat write, then two words that must be ignored
    task automatic wrB(input logic [7:0] c);
        st(WR, {3'h0, c}, {1'b1, wd(c)}, 4'h0, 8'h0);
        cmpv({9'h0, burstActive, burstWrite}, 11'h003);
        for (int k = 1; k < 6; k++) begin
            st(NOP, 11'h0, {1'b1, k < 4 ? wd(sq(c, k)) : ~wd(sq(c, k))}, 4'h0, 8'h0);
        end
        cmpv({9'h0, burstActive, burstWrite}, 11'h000);
    endtask
    // Four-beat read at latency two
    task automatic rdB(input logic [7:0] c, input logic [32:0] d);
        st(RD, {3'h0, c}, d, 4'h0, 8'h0);
        cmpv({9'h0, burstActive, burstWrite}, 11'h002);
        for (int k = 0; k < 4; k++) st(NOP, 11'h0, Z, 4'hF, sq(c, k));
        st(NOP, 11'h0, Z, 4'h0, 8'h0);
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        compares = 0;
        mk = 4'h0;
        rstn = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        cmpv(modeValue, 11'h032);
        cmpv({7'h0, bankOpen}, 11'h0);
        chk(4'h0, 8'h0);
        rstn = 1'b1;
        for (i = 0; i < 21000 && initDone !== 1'b1; i++) @(posedge sys_clk);
        if (initDone !== 1'b1) fail("init timeout");
        #1;
        cmpv(modeValue, 11'h022);
        st(ACT, 11'h005, Z, 4'h0, 8'h0);
        cmpv({7'h0, bankOpen}, 11'h004);
        nops(2);
        for (i = 8'h20; i < 8'h2C; i += 4) wrB(8'(i));
        // Write cut by a write, then by a read
        st(WR, 11'h020, {1'b1, wd(8'h20)}, 4'h0, 8'h0);
        st(NOP, 11'h0, {1'b1, wd(8'h21)}, 4'h0, 8'h0);
        wrB(8'h26);
        st(WR, 11'h028, {1'b1, wd(8'h28)}, 4'h0, 8'h0);
        rdB(8'h20, {1'b1, ~wd(8'h29)});
        rdB(8'h26, Z);
        rdB(8'h2B, Z);
        // Read cut by a read, deselect, byte mask, refused burst stop
        st(RD, 11'h020, Z, 4'h0, 8'h0);
        st(NOP, 11'h0, Z, 4'hF, 8'h20);
        st(RD, 11'h025, Z, 4'hF, 8'h21);
        st(DSW, 11'h02A, Z, 4'hF, 8'h25);
        mk = 4'h1;
        st(BST, 11'h0, Z, 4'hF, 8'h26);
        mk = 4'h0;
        st(NOP, 11'h0, Z, 4'hE, 8'h27);
        st(NOP, 11'h0, Z, 4'hF, 8'h24);
        nops(1);
        // Read cut by a write, masks floating the bus first
        mk = 4'hF;
        st(RD, 11'h020, Z, 4'h0, 8'h0);
        st(NOP, 11'h0, Z, 4'h0, 8'h0);
        mk = 4'h0;
        wrB(8'h2C);
        rdB(8'h2E, Z);
        // Interleaved eight-beat read at latency three
        st(PRE, 11'h400, Z, 4'h0, 8'h0);
        st(MRS, 11'h03B, Z, 4'h0, 8'h0);
        nops(2);
        st(ACT, 11'h005, Z, 4'h0, 8'h0);
        nops(1);
        st(RD, 11'h023, Z, 4'h0, 8'h0);
        nops(1);
        for (i = 0; i < 8; i++) st(NOP, 11'h0, Z, 4'hF, 8'h23 ^ 8'(i));
        nops(1);
        // Full-page bursts across the row end, ended by burst stop
        st(PRE, 11'h400, Z, 4'h0, 8'h0);
        st(MRS, 11'h027, Z, 4'h0, 8'h0);
        nops(2);
        st(ACT, 11'h005, Z, 4'h0, 8'h0);
        nops(1);
        st(WR, 11'h000, {1'b1, wd(8'h00)}, 4'h0, 8'h0);
        for (i = 1; i < 4; i++) st(NOP, 11'h0, {1'b1, wd(8'(i))}, 4'h0, 8'h0);
        st(BST, 11'h0, Z, 4'h0, 8'h0);
        st(WR, 11'h0FE, {1'b1, wd(8'hFE)}, 4'h0, 8'h0);
        st(NOP, 11'h0, {1'b1, wd(8'hFF)}, 4'h0, 8'h0);
        st(BST, 11'h0, {1'b1, ~wd(8'h00)}, 4'h0, 8'h0);
        st(NOP, 11'h0, {1'b1, ~wd(8'h01)}, 4'h0, 8'h0);
        st(RD, 11'h0FE, Z, 4'h0, 8'h0);
        for (i = 0; i < 5; i++) st(NOP, 11'h0, Z, 4'hF, 8'hFE + 8'(i));
        st(BST, 11'h0, Z, 4'hF, 8'h03);
        st(NOP, 11'h0, Z, 4'h0, 8'h0);
        nops(1);
        cmpv({10'h0, burstActive}, 11'h0);
        cmpv({7'h0, bankOpen}, 11'h004);
        // Two-beat read, then a single-beat read, at latency two
        st(PRE, 11'h400, Z, 4'h0, 8'h0);
        st(MRS, 11'h021, Z, 4'h0, 8'h0);
        nops(2);
        st(ACT, 11'h005, Z, 4'h0, 8'h0);
        nops(1);
        st(RD, 11'h021, Z, 4'h0, 8'h0);
        st(NOP, 11'h0, Z, 4'hF, 8'h21);
        st(NOP, 11'h0, Z, 4'hF, 8'h20);
        st(PRE, 11'h400, Z, 4'h0, 8'h0);
        st(MRS, 11'h020, Z, 4'h0, 8'h0);
        nops(2);
        st(ACT, 11'h005, Z, 4'h0, 8'h0);
        nops(1);
        st(RD, 11'h022, Z, 4'h0, 8'h0);
        cmpv({9'h0, burstActive, burstWrite}, 11'h000);
        st(NOP, 11'h0, Z, 4'hF, 8'h22);
        nops(1);
        end_sim;
    end
endmodule
